// file: logic/rpx_exchange.sv
// Remote point exchange: receive side mapping, transmit side filling,
// latched indicator clear and direct input source selection.
// Assumes message fields arrive as same-clock pulses from a network front
// end; only the clear button comes from a pin.
//
// Notes on behaviour
// R1 - Sixteen twenty-character slots; exact match accepts
// R2 - 32 inputs pick from 64 pairs
// R3 - Per-input originator selector, slots 1..16
// R4 - Per-input pair selector picks state
// R5 - Fallback at startup and originator offline
// R6 - On forces 1, Off forces 0
// R7 - Latest/On freezes, else shows 1
// R8 - Latest/Off freezes, else shows 0
// R9 - Resumes following messages once online again
// R10 - 32 predefined pairs, each with event enable
// R11 - Pair 21 reports local availability
// R12 - Pair 27 reports test mode; 28-32 reserved
// R13 - Pairs 14-17 report breaker closed states
// R14 - 32 user pairs from user operands
// R15 - Retransmit after idle interval without change
// R16 - Latches hold until clear command
// R17 - Clear releases only inactive latches; flags logged
// R18 - Three clear sources, common and own flag
// R19 - Direct input selects its source device
// R20 - Outgoing name is local device name
// R21 - Send at startup, change, idle; hold=3x
// R22 - Per-originator hold timer, restart, expire offline
// R23 - Invalid pair codes keep previous value
`default_nettype none

module rpx_exchange #(
  parameter int TICK_CYCLES = rpx_pkg::RPX_TICK_CYCLES
) (
  input  wire logic                                 ref_clk,
  input  wire logic                                 reset,
  // Receive side
  input  wire logic [rpx_pkg::RPX_SLOTS-1:0][rpx_pkg::RPX_ID_BITS-1:0]
                                                    originator_slot_identifier,
  input  wire logic                                 rx_valid,
  input  wire logic [rpx_pkg::RPX_ID_BITS-1:0]      rx_originator,
  input  wire logic [rpx_pkg::RPX_MS_W-1:0]         rx_hold_ms,
  input  wire logic [rpx_pkg::RPX_POINT_BITS-1:0]   rx_points,
  input  wire logic [rpx_pkg::RPX_INPUTS-1:0][rpx_pkg::RPX_SLOT_W-1:0]
                                                    remote_slot_select,
  input  wire logic [rpx_pkg::RPX_INPUTS-1:0][rpx_pkg::RPX_PAIR_W-1:0]
                                                    remote_pair_select,
  input  wire rpx_pkg::rpx_fallback_type            remote_fallback
                                                      [rpx_pkg::RPX_INPUTS],
  output logic [rpx_pkg::RPX_INPUTS-1:0]            remote_input,
  output logic [rpx_pkg::RPX_SLOTS-1:0]             originator_online,
  // Transmit side
  input  wire logic [rpx_pkg::RPX_ID_BITS-1:0]      local_originator_name,
  input  wire logic [rpx_pkg::RPX_PREDEF-1:0]       predefined_state,
  input  wire logic [rpx_pkg::RPX_USER-1:0]         user_state,
  input  wire logic                                 local_available,
  input  wire logic                                 local_test_mode,
  input  wire logic [3:0]                           breaker_closed,
  input  wire logic [rpx_pkg::RPX_PAIRS-1:0]        pair_event_enable,
  input  wire logic [rpx_pkg::RPX_IVL_W-1:0]        update_interval_ms,
  output logic [rpx_pkg::RPX_ID_BITS-1:0]           tx_name,
  output logic [rpx_pkg::RPX_POINT_BITS-1:0]        tx_points,
  output logic [rpx_pkg::RPX_HOLD_W-1:0]            tx_hold_ms,
  output logic                                      tx_request,
  output logic [rpx_pkg::RPX_PAIRS-1:0]             point_event,
  // Clear of latched indicators
  input  wire logic                                 clear_button_pin,
  input  wire logic                                 clear_comms,
  input  wire logic                                 clear_operand,
  input  wire logic [rpx_pkg::RPX_LATCHES-1:0]      latch_condition,
  output logic                                      clear_command_flag,
  output logic                                      clear_from_button_flag,
  output logic                                      clear_from_comms_flag,
  output logic                                      clear_from_operand_flag,
  output logic [rpx_pkg::RPX_LATCHES-1:0]           latched_indicator,
  // Direct inputs
  input  wire logic [rpx_pkg::RPX_DIRECT-1:0][rpx_pkg::RPX_SLOT_W-1:0]
                                                    direct_source_identifier,
  input  wire logic [rpx_pkg::RPX_SLOTS-1:0][rpx_pkg::RPX_DIRECT-1:0]
                                                    direct_device_bits,
  output logic [rpx_pkg::RPX_DIRECT-1:0]            direct_input
);
  import rpx_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  // ==========================================================
  // Millisecond tick divider
  logic [TICK_W-1:0] tick_count;
  logic              ms_tick;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tick_count <= '0;
      ms_tick    <= 1'b0;
    end else if (tick_count == TICK_W'(TICK_CYCLES - 1)) begin
      tick_count <= '0;
      ms_tick    <= 1'b1;
    end else begin
      tick_count <= tick_count + 1'b1;
      ms_tick    <= 1'b0;
    end
  end

  // ==========================================================
  // Originator match and hold timers
  logic [RPX_SLOTS-1:0] accept_slot;

  generate
    for (genvar gs = 0; gs < RPX_SLOTS; gs++) begin : g_slot
      // Whole identifier must match; no partial compare
      assign accept_slot[gs] = rx_valid &&
        (rx_originator == originator_slot_identifier[gs]);  // R1

      rpx_hold_timer u_hold (
        .ref_clk (ref_clk),
        .reset   (reset),
        .ms_tick (ms_tick),
        .accept  (accept_slot[gs]),
        .hold_ms (rx_hold_ms),
        .online  (originator_online[gs])
      );
    end
  endgenerate

  // ==========================================================
  // Remote inputs
  logic [RPX_INPUTS-1:0] latest, known;

  generate
    for (genvar gi = 0; gi < RPX_INPUTS; gi++) begin : g_input
      logic [RPX_SLOT_W-1:0] slot;
      logic [1:0]            code;
      logic                  hit;

      assign slot = remote_slot_select[gi];                  // R3
      assign code = rx_points[2*remote_pair_select[gi] +: 2]; // R2 R4
      assign hit  = accept_slot[slot];

      // Latest received value; a bad code leaves it untouched
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          latest[gi] <= 1'b0;
          known[gi]  <= 1'b0;
        end else if (hit && code == RPX_CODE_ON) begin
          latest[gi] <= 1'b1;                                // R23
          known[gi]  <= 1'b1;
        end else if (hit && code == RPX_CODE_OFF) begin
          latest[gi] <= 1'b0;                                // R23
          known[gi]  <= 1'b1;
        end
      end

      // Follow while online once a valid code is known, otherwise apply the fallback
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          remote_input[gi] <= 1'b0;
        end else if (originator_online[slot] && known[gi]) begin
          remote_input[gi] <= latest[gi];                    // R9
        end else begin
          unique case (remote_fallback[gi])                  // R5
            RPX_FB_ON:         remote_input[gi] <= 1'b1;     // R6
            RPX_FB_OFF:        remote_input[gi] <= 1'b0;     // R6
            RPX_FB_LATEST_ON:  remote_input[gi] <=
                                 known[gi] ? latest[gi] : 1'b1; // R7
            RPX_FB_LATEST_OFF: remote_input[gi] <=
                                 known[gi] & latest[gi];     // R8
          endcase
        end
      end
    end
  endgenerate

  // ==========================================================
  // Outgoing point image
  logic [RPX_POINT_BITS-1:0] next_points;
  logic [RPX_PAIRS-1:0]      pair_changed;

  function automatic logic [1:0] encode(input logic state);
    return state ? RPX_CODE_ON : RPX_CODE_OFF;
  endfunction

  always_comb begin
    next_points = '0;
    for (int p = 1; p <= RPX_PREDEF; p++) begin
      if (p >= RPX_PAIR_RESV_LO && p <= RPX_PAIR_RESV_HI) begin
        next_points[2*(p-1) +: 2] = 2'h0;                    // R12
      end else if (p == RPX_PAIR_STATUS) begin
        next_points[2*(p-1) +: 2] = encode(local_available); // R11
      end else if (p == RPX_PAIR_MODE) begin
        next_points[2*(p-1) +: 2] = encode(local_test_mode); // R12
      end else if (p >= RPX_PAIR_BKR_3PH && p <= RPX_PAIR_BKR_C) begin
        next_points[2*(p-1) +: 2] =
          encode(breaker_closed[p-RPX_PAIR_BKR_3PH]);        // R13
      end else begin
        next_points[2*(p-1) +: 2] = encode(predefined_state[p-1]); // R10
      end
    end
    for (int u = 0; u < RPX_USER; u++) begin
      next_points[2*(RPX_PREDEF+u) +: 2] = encode(user_state[u]); // R14
    end
  end

  // Per-pair change detect against what was last sent
  always_comb begin
    for (int q = 0; q < RPX_PAIRS; q++) begin
      pair_changed[q] = next_points[2*q +: 2] != tx_points[2*q +: 2];
    end
  end

  // ==========================================================
  // Transmit scheduling
  // The idle count restarts on every send, so a steady image goes out
  // once per interval and a busy one goes out on each change.
  logic                 started, idle_due, send_now;
  logic [RPX_MS_W-1:0]  idle_ms;

  assign idle_due = ms_tick &&
    (idle_ms + 1'b1 >= RPX_MS_W'(update_interval_ms));       // R15
  assign send_now = !started || (|pair_changed) || idle_due; // R21

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      started     <= 1'b0;
      idle_ms     <= '0;
      tx_request  <= 1'b0;
      tx_points   <= '0;
      point_event <= '0;
    end else begin
      started     <= 1'b1;
      tx_request  <= send_now;                               // R21
      tx_points   <= next_points;
      point_event <= pair_changed & pair_event_enable &      // Startup image is no change
                     {RPX_PAIRS{started}};                   // R10
      if (send_now) begin
        idle_ms <= '0;
      end else if (ms_tick) begin
        idle_ms <= idle_ms + 1'b1;
      end
    end
  end

  // Name and hold advertised with every message
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_name    <= '0;
      tx_hold_ms <= '0;
    end else begin
      tx_name    <= local_originator_name;                   // R20
      tx_hold_ms <= RPX_HOLD_W'(RPX_HOLD_FACTOR) *
                    RPX_HOLD_W'(update_interval_ms);         // R21
    end
  end

  // ==========================================================
  // Clear command sources
  // Button is a pin; comms and operand come from same-clock logic
  logic button_meta, button_sync, button_last;
  logic comms_last, operand_last;
  logic rise_button, rise_comms, rise_operand;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      button_meta  <= 1'b0;
      button_sync  <= 1'b0;
      button_last  <= 1'b0;
      comms_last   <= 1'b0;
      operand_last <= 1'b0;
    end else begin
      button_meta  <= clear_button_pin;
      button_sync  <= button_meta;
      button_last  <= button_sync;
      comms_last   <= clear_comms;
      operand_last <= clear_operand;
    end
  end

  assign rise_button  = button_sync & ~button_last;
  assign rise_comms   = clear_comms & ~comms_last;
  assign rise_operand = clear_operand & ~operand_last;

  // One-cycle flags; they double as the logged clear events
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clear_command_flag      <= 1'b0;
      clear_from_button_flag  <= 1'b0;
      clear_from_comms_flag   <= 1'b0;
      clear_from_operand_flag <= 1'b0;
    end else begin
      clear_command_flag      <= rise_button | rise_comms
                                 | rise_operand;             // R18
      clear_from_button_flag  <= rise_button;                // R18
      clear_from_comms_flag   <= rise_comms;                 // R18
      clear_from_operand_flag <= rise_operand;               // R18
    end
  end

  // ==========================================================
  // Latched indicators
  // An active condition always wins, so a clear cannot drop a live alarm
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      latched_indicator <= '0;
    end else begin
      latched_indicator <= latch_condition |                 // R16
        (latched_indicator &
         ~({RPX_LATCHES{clear_command_flag}} & ~latch_condition)); // R17
    end
  end

  // ==========================================================
  // Direct inputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      direct_input <= '0;
    end else begin
      for (int d = 0; d < RPX_DIRECT; d++) begin
        direct_input[d] <=
          direct_device_bits[direct_source_identifier[d]][d]; // R19
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Gated by started: the reset release edge still sees reset values
  a_hold_triple : assert property (started |-> // R21
    tx_hold_ms == RPX_HOLD_W'(RPX_HOLD_FACTOR) *
                  RPX_HOLD_W'($past(update_interval_ms)))
    else $error("advertised hold is not three intervals");
  a_status_pair : assert property (started |-> // R11
    tx_points[2*(RPX_PAIR_STATUS-1) +: 2] ==
      ($past(local_available) ? RPX_CODE_ON : RPX_CODE_OFF))
    else $error("status pair does not follow availability");
  a_reserved_zero : assert property ( // R12
    tx_points[2*RPX_PREDEF-1:2*(RPX_PAIR_RESV_LO-1)] == '0)
    else $error("reserved pairs not zero");
  a_change_sends : assert property ( // R21
    started && (|pair_changed) |=> tx_request)
    else $error("changed image not sent");
  a_fallback_force : assert property (started && // R6
    !originator_online[remote_slot_select[0]] &&
      remote_fallback[0] == RPX_FB_ON |=> remote_input[0])
    else $error("forced-on fallback not applied");
  a_clear_common : assert property ( // R18
    clear_from_button_flag || clear_from_comms_flag ||
      clear_from_operand_flag |-> clear_command_flag)
    else $error("source flag without common clear flag");
  a_latch_holds : assert property ( // R16
    latched_indicator[0] && !clear_command_flag |=>
      latched_indicator[0])
    else $error("latch dropped without clear");
  a_clear_release : assert property ( // R17
    latched_indicator[0] && clear_command_flag && !latch_condition[0]
      |=> !latched_indicator[0])
    else $error("inactive latch not released by clear");

  c_button_clear : cover property (rise_button ##1 clear_from_button_flag);
  c_slot_online  : cover property ($rose(originator_online[0]));
  c_idle_send    : cover property (idle_due ##1 tx_request);
  c_latch_clear  : cover property ($fell(latched_indicator[0]));

endmodule

`default_nettype wire

// file: shared/rpx_pkg.sv
// Shared constants and types of the remote point exchange block.
// Assumes a single 100 MHz system clock and a same-clock network front end.
`default_nettype none

package rpx_pkg;

  // ==========================================================
  // Sizes
  localparam int RPX_SLOTS      = 16;  // Originator slots
  localparam int RPX_ID_CHARS   = 20;  // Characters per identifier
  localparam int RPX_ID_BITS    = RPX_ID_CHARS * 8;
  localparam int RPX_INPUTS     = 32;  // Remote inputs
  localparam int RPX_PREDEF     = 32;  // Predefined pairs
  localparam int RPX_USER       = 32;  // User pairs
  localparam int RPX_PAIRS      = RPX_PREDEF + RPX_USER;
  localparam int RPX_POINT_BITS = RPX_PAIRS * 2;
  localparam int RPX_SLOT_W     = 4;   // Encodes slots 1..16 as 0..15
  localparam int RPX_PAIR_W     = 6;   // 0..31 predefined, 32..63 user
  localparam int RPX_LATCHES    = 16;  // Latched indicators
  localparam int RPX_DIRECT     = 32;  // Direct inputs
  localparam int RPX_MS_W       = 32;  // Millisecond timer width
  localparam int RPX_IVL_W      = 16;  // Idle interval width
  localparam int RPX_HOLD_W     = 18;  // Advertised hold width

  // ==========================================================
  // Predefined pair numbers, counted from 1
  localparam int RPX_PAIR_BKR_3PH   = 14;
  localparam int RPX_PAIR_BKR_A     = 15;
  localparam int RPX_PAIR_BKR_B     = 16;
  localparam int RPX_PAIR_BKR_C     = 17;
  localparam int RPX_PAIR_STATUS    = 21;
  localparam int RPX_PAIR_MODE      = 27;
  localparam int RPX_PAIR_RESV_LO   = 28;
  localparam int RPX_PAIR_RESV_HI   = 32;

  // ==========================================================
  // Two-bit point codes; 2'b00 and 2'b11 are invalid
  localparam logic [1:0] RPX_CODE_ON  = 2'h2;
  localparam logic [1:0] RPX_CODE_OFF = 2'h1;

  // ==========================================================
  // Timing
  localparam int RPX_CLK_HZ      = 100_000_000;
  localparam int RPX_TICK_MS     = 1;
  localparam int RPX_TICK_CYCLES = RPX_CLK_HZ / 1000 * RPX_TICK_MS;
  localparam int RPX_HOLD_FACTOR = 3;

  // ==========================================================
  // Fallback behaviour of a remote input
  typedef enum logic [1:0] {
    RPX_FB_ON,
    RPX_FB_OFF,
    RPX_FB_LATEST_ON,
    RPX_FB_LATEST_OFF
  } rpx_fallback_type;

endpackage

`default_nettype wire

// file: logic/rpx_hold_timer.sv
// Hold timer for one originator slot.
// Assumes a one-cycle millisecond tick and an accept pulse on the same clock.
`default_nettype none

module rpx_hold_timer (
  input  wire logic                         ref_clk,
  input  wire logic                         reset,
  input  wire logic                         ms_tick,
  input  wire logic                         accept,
  input  wire logic [rpx_pkg::RPX_MS_W-1:0] hold_ms,
  output logic                              online
);
  import rpx_pkg::*;

  logic [RPX_MS_W-1:0] remaining;

  // ==========================================================
  // Countdown
  // Offline from reset so startup counts as lost communication
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      remaining <= '0;
      online    <= 1'b0;
    end else if (accept) begin
      remaining <= hold_ms;                          // R22
      online    <= (hold_ms != '0);                  // R9
    end else if (ms_tick && online) begin
      remaining <= remaining - 1'b1;
      if (remaining <= RPX_MS_W'(1)) begin
        online <= 1'b0;                              // R22
      end
    end
  end

  // ==========================================================
  // Checks
  a_accept_online : assert property ( // R22
    @(posedge ref_clk) disable iff (reset)
    accept && hold_ms != '0 |=> online)
    else $error("originator not online after accepted message");
  a_expiry_offline : assert property ( // R22
    @(posedge ref_clk) disable iff (reset)
    online && ms_tick && remaining == RPX_MS_W'(1) && !accept
      |=> !online)
    else $error("originator still online after hold expiry");

endmodule

`default_nettype wire

// file: tb/rpx_peer_model.sv
// Peer relay model: sends status messages into the receive side.
// Assumes the bench calls send() from its main sequence, on ref_clk.
`default_nettype none

module rpx_peer_model (
  input  wire logic                             ref_clk,
  output logic                                  rx_valid,
  output logic [rpx_pkg::RPX_ID_BITS-1:0]       rx_originator,
  output logic [rpx_pkg::RPX_MS_W-1:0]          rx_hold_ms,
  output logic [rpx_pkg::RPX_POINT_BITS-1:0]    rx_points
);
  timeunit 1ns;
  timeprecision 1ps;
  import rpx_pkg::*;

  // ==========================================================
  // Idle values at time zero
  initial begin
    rx_valid      = 1'b0;
    rx_originator = '0;
    rx_hold_ms    = '0;
    rx_points     = '0;
  end

  // One message, one cycle wide; id and point lines show the inverse afterwards, hold keeps its value
  task automatic send(input logic [RPX_ID_BITS-1:0] id,
                      input logic [RPX_MS_W-1:0] ivl,
                      input logic [RPX_POINT_BITS-1:0] pts);
    @(posedge ref_clk);
    rx_valid      <= 1'b1;
    rx_originator <= id;
    rx_hold_ms    <= 3 * ivl;
    rx_points     <= pts;
    @(posedge ref_clk);
    rx_valid      <= 1'b0;
    rx_originator <= ~id;
    rx_points     <= ~pts;
  endtask
endmodule

`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the remote point exchange block.
// Assumes the peer model drives the receive side; ms tick is 10 cycles.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rpx_pkg::*;

  // ==========================================================
  // Signals
  logic               ref_clk, reset, rx_valid, tx_request;
  logic               local_available, local_test_mode, clear_button_pin;
  logic               clear_comms, clear_operand, clear_command_flag;
  logic               clear_from_button_flag, clear_from_comms_flag;
  logic               clear_from_operand_flag;
  logic [15:0][159:0] originator_slot_identifier;
  logic [159:0]       rx_originator, tx_name, local_originator_name;
  logic [31:0]        rx_hold_ms, remote_input, predefined_state;
  logic [31:0]        user_state, direct_input;
  logic [127:0]       rx_points, tx_points;
  logic [31:0][3:0]   remote_slot_select, direct_source_identifier;
  logic [31:0][5:0]   remote_pair_select;
  rpx_fallback_type   remote_fallback [RPX_INPUTS];
  logic [15:0]        originator_online, update_interval_ms;
  logic [15:0]        latch_condition, latched_indicator;
  logic [3:0]         breaker_closed;
  logic [63:0]        pair_event_enable, point_event;
  logic [17:0]        tx_hold_ms;
  logic [15:0][31:0]  direct_device_bits;
  int                 fail_count, check_count;

  // ==========================================================
  // Instances
  rpx_exchange #(.TICK_CYCLES(10)) u_rpx_exchange (
    .ref_clk, .reset, .originator_slot_identifier, .rx_valid,
    .rx_originator, .rx_hold_ms, .rx_points, .remote_slot_select,
    .remote_pair_select, .remote_fallback, .remote_input,
    .originator_online, .local_originator_name, .predefined_state,
    .user_state, .local_available, .local_test_mode, .breaker_closed,
    .pair_event_enable, .update_interval_ms, .tx_name, .tx_points,
    .tx_hold_ms, .tx_request, .point_event, .clear_button_pin,
    .clear_comms, .clear_operand, .latch_condition, .clear_command_flag,
    .clear_from_button_flag, .clear_from_comms_flag,
    .clear_from_operand_flag, .latched_indicator,
    .direct_source_identifier, .direct_device_bits, .direct_input
  );
  rpx_peer_model u_rpx_peer_model (
    .ref_clk, .rx_valid, .rx_originator, .rx_hold_ms, .rx_points
  );

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [159:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Bounded poll: 0 send, 1 clear flag, 2 slot 1 offline; timeout fails
  task automatic wait_for(input int which, output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while ((which == 2 ? !originator_online[0] :
                which == 1 ? clear_command_flag : tx_request) !== 1'b1
               && n < 200);
    if (n >= 200) begin
      fail_count++;
      give_verdict();
    end
  endtask

  // Pair 1, pair 2 and user pair 1 of an incoming message
  function automatic logic [127:0] pts(input logic [1:0] a, b);
    pts = '0;
    pts[1:0] = a;
    pts[3:2] = b;
    pts[65:64] = 2'b10;
  endfunction

  // Message with a 2 ms peer interval, then wait until inputs settle
  task automatic rx(input logic [159:0] id, input logic [127:0] p);
    u_rpx_peer_model.send(id, 32'h2, p);
    @(posedge ref_clk);
    #1;
  endtask

  // ==========================================================
  // Scenarios
  task automatic do_receive();
    int n;
    check("startup_send", tx_request, 1'b1);
    check("startup_event", point_event, 64'h0);
    repeat (2) @(posedge ref_clk);
    #1;
    check("startup_fallback", remote_input[5:0], 6'h15);
    rx("peer_alpha", pts(2'b01, 2'b10));
    check("rin_first", remote_input[5:0], 6'h38);
    check("online", originator_online, 16'h0001);
    rx("peer_alphb", pts(2'b10, 2'b01));
    check("rin_foreign", remote_input[5:0], 6'h38);
    check("online_foreign", originator_online, 16'h0001);
    rx("peer_alpha", pts(2'b11, 2'b00));
    check("rin_invalid", remote_input[5:0], 6'h38);
    wait_for(2, n);
    check("hold_span", n >= 50 && n <= 59, 1'b1);
    @(posedge ref_clk);
    #1;
    check("rin_frozen", remote_input[5:0], 6'h19);
    rx("peer_alpha", pts(2'b10, 2'b01));
    check("rin_resumed", remote_input[5:0], 6'h37);
  endtask

  // Outgoing image, dedicated pairs and change-driven sends
  task automatic do_transmit();
    int n;
    @(posedge ref_clk);
    local_available <= 1'b1;
    local_test_mode <= 1'b1;
    breaker_closed <= 4'b0101;
    predefined_state <= 32'hffffffff;
    user_state <= 32'h1;
    update_interval_ms <= 16'h5;
    local_originator_name <= "local_two";
    repeat (3) @(posedge ref_clk);
    #1;
    check("pair1", tx_points[1:0], 2'b10);
    check("breaker", tx_points[33:26], 8'b01100110);
    check("status", tx_points[41:40], 2'b10);
    check("mode", tx_points[53:52], 2'b10);
    check("reserved", tx_points[63:54], 10'h0);
    check("user", tx_points[67:64], 4'b0110);
    check("name", tx_name, "local_two");
    check("hold_adv", tx_hold_ms, 18'd15);
    @(posedge ref_clk);
    user_state <= 32'h3;
    pair_event_enable <= 64'hfffffffbffffffff;
    @(posedge ref_clk);
    #1;
    check("chg_send", tx_request, 1'b1);
    check("chg_event", point_event[33], 1'b1);
    @(posedge ref_clk);
    user_state <= 32'h7;
    @(posedge ref_clk);
    #1;
    check("chg_send2", tx_request, 1'b1);
    check("masked_event", point_event[34], 1'b0);
    wait_for(0, n);
    wait_for(0, n);
    check("idle_gap", n >= 45 && n <= 60, 1'b1);
  endtask

  // Each clear source in turn; the latch with a live condition stays
  task automatic do_clear();
    int n;
    @(posedge ref_clk);
    latch_condition <= 16'h0003;
    @(posedge ref_clk);
    latch_condition <= 16'h0002;
    repeat (3) @(posedge ref_clk);
    #1;
    check("latched", latched_indicator, 16'h0003);
    for (int s = 0; s < 3; s++) begin
      @(posedge ref_clk);
      {clear_button_pin, clear_comms, clear_operand} <= 3'b100 >> s;
      latch_condition <= 16'h0002;
      wait_for(1, n);
      check("clear_src", {clear_from_button_flag, clear_from_comms_flag,
            clear_from_operand_flag}, 3'b100 >> s);
      @(posedge ref_clk);
      #1;
      check("released", latched_indicator, 16'h0002);
      check("one_pulse", clear_command_flag, 1'b0);
      @(posedge ref_clk);
      {clear_button_pin, clear_comms, clear_operand} <= 3'b000;
      latch_condition <= 16'h0003;
    end
  endtask

  // Direct input follows the device that its selector names
  task automatic do_direct();
    @(posedge ref_clk);
    direct_source_identifier[3] <= 4'h5;
    direct_device_bits[5] <= 32'h8;
    direct_device_bits[3] <= 32'hfffffff7;
    repeat (2) @(posedge ref_clk);
    #1;
    check("direct_dev5", direct_input[3], 1'b1);
    @(posedge ref_clk);
    direct_source_identifier[3] <= 4'h3;
    repeat (2) @(posedge ref_clk);
    #1;
    check("direct_dev3", direct_input[3], 1'b0);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    fail_count = 0;
    check_count = 0;
    reset = 1'b1;
    originator_slot_identifier = '0;
    originator_slot_identifier[0] = "peer_alpha";
    originator_slot_identifier[1] = "peer_beta";
    remote_slot_select = '0;
    remote_slot_select[4] = 4'h1;
    remote_pair_select = '0;
    remote_pair_select[3] = 6'h01;
    remote_pair_select[5] = 6'h20;
    foreach (remote_fallback[i]) remote_fallback[i] = RPX_FB_OFF;
    remote_fallback[0] = RPX_FB_ON;
    remote_fallback[2] = RPX_FB_LATEST_ON;
    remote_fallback[3] = RPX_FB_LATEST_OFF;
    remote_fallback[4] = RPX_FB_ON;
    local_originator_name = "local_one";
    predefined_state = '0;
    user_state = '0;
    local_available = 1'b0;
    local_test_mode = 1'b0;
    breaker_closed = '0;
    pair_event_enable = '1;
    update_interval_ms = 16'h3;
    {clear_button_pin, clear_comms, clear_operand} = 3'b000;
    latch_condition = '0;
    direct_source_identifier = '0;
    direct_device_bits = '0;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    do_receive();
    do_transmit();
    do_clear();
    do_direct();
    give_verdict();
  end
endmodule

`default_nettype wire
